// *** fp_state_save_image.sv ***
// Design decisions made here: the placing of the registers and the APB slave port.
module fp_state_save_image (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire fp_image_pkg::apb_req_t apb_req,
  output fp_image_pkg::apb_rsp_t      apb_rsp,
  // interrupt
  output logic                        irq
);
  import fp_image_pkg::*;

  state_t s_reg;   // registered state
  state_t s_next;  // next state

  // access phase not yet answered
  logic access;
  // index into the image window
  logic [7:0] widx;
  logic       in_img;
  logic       in_rng;  // word index inside the image
  logic       long_m;
  logic       osfs;
  logic [2:0] top;

  assign access = apb_req.psel && apb_req.penable && !s_reg.rsp.pready;
  assign widx   = apb_req.paddr[9:2];
  // whole window is image space, so words past the end never reach register decode
  assign in_img = (apb_req.paddr[11:10] == IMG_SEL);
  assign in_rng = (widx < W_END);
  assign long_m = s_reg.ctrl[CTRL_LONG];
  assign osfs   = s_reg.ctrl[CTRL_OSFS];
  assign top    = s_reg.sw[SW_TOP+2:SW_TOP];

  // full tag of one physical register from its contents
  function automatic logic [1:0] full_tag(input logic [79:0] r, input logic used);
    logic [14:0] e;
    logic        j;
    logic        f0;
    e  = r[78:64];
    j  = r[63];
    f0 = (r[62:0] == 63'h0);
    if (!used) begin
      full_tag = TAG_EMPTY;
    end else if (e == 15'h0) begin
      // zero or denormal
      full_tag = (!j && f0) ? TAG_ZERO : TAG_SPECIAL;
    end else if (e == 15'h7FFF) begin
      // infinity, nan, pseudo forms
      full_tag = TAG_SPECIAL;
    end else begin
      // normal or unnormal
      full_tag = j ? TAG_VALID : TAG_SPECIAL;
    end
  endfunction : full_tag

  // sixteen-bit tag word assembled from all registers
  function automatic logic [15:0] tag_word(input state_t s);
    logic [15:0] t;
    t = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      t[2*i +: 2] = full_tag(s.fp_data_reg[i], s.tagc[i]);
    end
    tag_word = t;
  endfunction : tag_word

  // one word of the saved image
  function automatic logic [31:0] img_word(input state_t s, input logic [7:0] w);
    logic [7:0]  k;
    logic [2:0]  ph;
    logic [3:0]  m;
    logic [79:0] f;
    logic        lm;
    lm = s.ctrl[CTRL_LONG];
    k  = 8'h00;
    ph = 3'h0;
    m  = 4'h0;
    f  = 80'h0;
    img_word = 32'h0000_0000;
    if (w >= W_XMM) begin
      k = w - W_XMM;
      m = k[5:2];
      if (s.ctrl[CTRL_OSFS] && (lm || !m[3])) begin
        img_word = s.wide_media_reg[m][32*k[1:0] +: 32];
      end
    end else if (w >= W_FPR) begin
      k  = w - W_FPR;
      ph = k[4:2] + s.sw[SW_TOP+2:SW_TOP];
      f  = s.fp_data_reg[ph];
      case (k[1:0])
        2'h0:    img_word = f[31:0];
        2'h1:    img_word = f[63:32];
        2'h2:    img_word = {16'h0000, f[79:64]};
        default: img_word = 32'h0000_0000;
      endcase
    end else begin
      case (w)
        W_CWSW:  img_word = {s.sw, s.cw};
        W_TAGOP: img_word = {{(16-OPC_W){1'b0}}, s.opc, RESV_BYTE, s.tagc};
        W_IPLO:  img_word = s.ip[31:0];
        W_IPHI:  img_word = lm ? s.ip[63:32] : {16'h0000, s.cs};
        W_DPLO:  img_word = s.memref ? s.dp[31:0] : 32'h0000_0000;
        W_DPHI:  img_word = !s.memref ? 32'h0000_0000 :
                            lm ? s.dp[63:32] : {16'h0000, s.ds};
        W_MCTL:  img_word = s.ctrl[CTRL_OSFS] ? s.mctl : 32'h0000_0000;
        W_MASK:  img_word = SUPPORT_MASK;
        default: img_word = 32'h0000_0000;
      endcase
    end
  endfunction : img_word

  // next state
  always_comb begin
    logic [31:0] wd;
    logic [1:0]  ev;
    logic [1:0]  clr;
    logic [7:0]  k;
    logic [2:0]  ph;
    logic [3:0]  m;
    logic        hit;
    wd  = apb_req.pwdata;
    ev  = 2'h0;
    clr = 2'h0;
    k   = 8'h00;
    ph  = 3'h0;
    m   = 4'h0;
    hit = 1'b1;
    s_next = s_reg;
    // answer lasts one cycle
    s_next.rsp.pready  = 1'b0;
    s_next.rsp.pslverr = 1'b0;
    if (access) begin
      s_next.rsp.pready = 1'b1;
      s_next.rsp.prdata = 32'h0000_0000;
      if (in_img) begin
        // image window read and restore, zero and no effect past the end
        if (in_rng) s_next.rsp.prdata = img_word(s_reg, widx);
        if (apb_req.pwrite && in_rng) begin
          if (widx >= W_XMM) begin
            k = widx - W_XMM;
            m = k[5:2];
            if (osfs && (long_m || !m[3])) begin
              s_next.wide_media_reg[m][32*k[1:0] +: 32] = wd;
            end
          end else if (widx >= W_FPR) begin
            k  = widx - W_FPR;
            ph = k[4:2] + top;
            case (k[1:0])
              2'h0:    s_next.fp_data_reg[ph][31:0] = wd;
              2'h1:    s_next.fp_data_reg[ph][63:32] = wd;
              2'h2:    s_next.fp_data_reg[ph][79:64] = wd[15:0];
              default: s_next.fp_data_reg[ph] = s_reg.fp_data_reg[ph];
            endcase
          end else begin
            case (widx)
              W_CWSW: begin
                s_next.cw = wd[15:0];
                s_next.sw = wd[31:16];
              end
              W_TAGOP: begin
                s_next.tagc = wd[7:0];
                s_next.opc  = wd[16 +: OPC_W];
              end
              W_IPLO: s_next.ip[31:0] = wd;
              W_IPHI: begin
                if (long_m) begin
                  s_next.ip[63:32] = wd;
                end else begin
                  s_next.cs = wd[15:0];
                end
              end
              W_DPLO: begin
                s_next.dp[31:0] = wd;
                s_next.memref   = 1'b1;
              end
              W_DPHI: begin
                if (long_m) begin
                  s_next.dp[63:32] = wd;
                end else begin
                  s_next.ds = wd[15:0];
                end
              end
              W_MCTL: begin
                if ((wd & ~SUPPORT_MASK) != 32'h0000_0000) begin
                  ev[EV_FAULT] = 1'b1;
                end else if (osfs) begin
                  s_next.mctl = wd;
                end
              end
              default: s_next.cw = s_reg.cw;
            endcase
          end
        end
      end else begin
        // register space
        case (apb_req.paddr)
          ADDR_CTRL: begin
            s_next.rsp.prdata = {29'h0, s_reg.ctrl};
            if (apb_req.pwrite) s_next.ctrl = wd[2:0];
          end
          ADDR_STATUS: s_next.rsp.prdata = {31'h0, s_reg.memref};
          ADDR_INT_STAT: s_next.rsp.prdata = {30'h0, s_reg.int_stat};
          ADDR_INT_CLR: begin
            if (apb_req.pwrite) clr = wd[1:0];
          end
          ADDR_INT_EN: begin
            s_next.rsp.prdata = {30'h0, s_reg.int_en};
            if (apb_req.pwrite) s_next.int_en = wd[1:0];
          end
          ADDR_CWSW: begin
            s_next.rsp.prdata = {s_reg.sw, s_reg.cw};
            if (apb_req.pwrite) begin
              s_next.cw = wd[15:0];
              s_next.sw = wd[31:16];
            end
          end
          ADDR_TAG: begin
            s_next.rsp.prdata = {16'h0000, tag_word(s_reg)};
            if (apb_req.pwrite) begin
              for (int i = 0; i < 8; i++) begin
                s_next.tagc[i] = (wd[2*i +: 2] != TAG_EMPTY);
              end
            end
          end
          ADDR_EXEC: begin
            if (apb_req.pwrite) begin
              if (s_reg.ctrl[CTRL_LAZY]) begin
                ev[EV_TRAP] = 1'b1;
              end else if (!wd[EXEC_CTRL]) begin
                s_next.opc    = wd[OPC_W-1:0];
                s_next.memref = wd[EXEC_MEM];
              end
            end
          end
          ADDR_MCTL: begin
            s_next.rsp.prdata = s_reg.mctl;
            if (apb_req.pwrite) begin
              if ((wd & ~SUPPORT_MASK) != 32'h0000_0000) begin
                ev[EV_FAULT] = 1'b1;
              end else begin
                s_next.mctl = wd;
              end
            end
          end
          ADDR_TASK_SW: begin
            if (apb_req.pwrite && !long_m) begin
              s_next.ctrl[CTRL_LAZY] = 1'b1;
            end
          end
          default: hit = 1'b0;
        endcase
        // unmapped address answers with error
        s_next.rsp.pslverr = !hit;
      end
    end
    // sticky events, set beats clear
    s_next.int_stat = (s_reg.int_stat & ~clr) | ev;
    s_next.irq      = |(s_next.int_stat & s_next.int_en);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flops
  assign apb_rsp = s_reg.rsp;
  assign irq     = s_reg.irq;
endmodule : fp_state_save_image

// *** fp_image_pkg.sv ***
package fp_image_pkg;
  // register byte offsets
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam logic [11:0] ADDR_INT_STAT = 12'h008;
  localparam logic [11:0] ADDR_INT_CLR  = 12'h00C;
  localparam logic [11:0] ADDR_INT_EN   = 12'h010;
  localparam logic [11:0] ADDR_CWSW     = 12'h014;
  localparam logic [11:0] ADDR_TAG      = 12'h018;
  localparam logic [11:0] ADDR_EXEC     = 12'h01C;
  localparam logic [11:0] ADDR_MCTL     = 12'h020;
  localparam logic [11:0] ADDR_TASK_SW  = 12'h024;
  // image window select: paddr[11:10]
  localparam logic [1:0]  IMG_SEL       = 2'h1;
  // control bits
  localparam int CTRL_OSFS = 0;
  localparam int CTRL_LONG = 1;
  localparam int CTRL_LAZY = 2;
  // status bits
  localparam int STAT_MEMREF = 0;
  // event bits
  localparam int EV_TRAP  = 0;
  localparam int EV_FAULT = 1;
  // exec word fields
  localparam int EXEC_MEM  = 16;
  localparam int EXEC_CTRL = 17;
  localparam int OPC_W     = 11;
  // status word top-of-stack field
  localparam int SW_TOP = 11;
  // media control support mask, bit 6 is denormal_zero_mode
  localparam logic [31:0] SUPPORT_MASK = 32'h0000_FFFF;
  localparam logic [7:0]  RESV_BYTE    = 8'h00;
  // image word indices
  localparam logic [7:0] W_CWSW  = 8'h00;
  localparam logic [7:0] W_TAGOP = 8'h01;
  localparam logic [7:0] W_IPLO  = 8'h02;
  localparam logic [7:0] W_IPHI  = 8'h03;
  localparam logic [7:0] W_DPLO  = 8'h04;
  localparam logic [7:0] W_DPHI  = 8'h05;
  localparam logic [7:0] W_MCTL  = 8'h06;
  localparam logic [7:0] W_MASK  = 8'h07;
  localparam logic [7:0] W_FPR   = 8'h08;
  localparam logic [7:0] W_XMM   = 8'h28;
  // wide regs 8-15 follow wide reg 7, present in 64-bit mode only
  localparam logic [7:0] W_END   = 8'h68;
  // full tag codes
  localparam logic [1:0] TAG_VALID   = 2'h0;
  localparam logic [1:0] TAG_ZERO    = 2'h1;
  localparam logic [1:0] TAG_SPECIAL = 2'h2;
  localparam logic [1:0] TAG_EMPTY   = 2'h3;
  // reset values
  localparam logic [15:0] CW_RESET = 16'h0000;
  localparam logic [7:0]  TAG_RESET = 8'h00;

  // apb request from master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // apb answer to master
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  // whole block state
  typedef struct packed {
    logic [2:0]            ctrl;
    logic [1:0]            int_stat;
    logic [1:0]            int_en;
    logic [15:0]           cw;
    logic [15:0]           sw;
    logic [7:0]            tagc;
    logic [OPC_W-1:0]      opc;
    logic [63:0]           ip;
    logic [15:0]           cs;
    logic [63:0]           dp;
    logic [15:0]           ds;
    logic                  memref;
    logic [31:0]           mctl;
    logic [7:0][79:0]      fp_data_reg;
    logic [15:0][127:0]    wide_media_reg;
    apb_rsp_t              rsp;
    logic                  irq;
  } state_t;
endpackage : fp_image_pkg

// *** fp_image_asserts.sv ***
module fp_image_asserts (
  // clock and reset
  input wire logic                   pclk,
  input wire logic                   presetn,
  // apb
  input wire fp_image_pkg::apb_req_t apb_req,
  input wire fp_image_pkg::apb_rsp_t apb_rsp,
  // interrupt
  input wire logic                   irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import fp_image_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // first access cycle of a transfer
  logic acc;
  assign acc = apb_req.psel && apb_req.penable && !apb_rsp.pready;
  // read in first access cycle
  logic rd;
  assign rd = acc && !apb_req.pwrite;
  // write in first access cycle
  logic wr_acc;
  assign wr_acc = acc && apb_req.pwrite;
  // image window decode
  logic img;
  assign img = apb_req.paddr[11:10] == IMG_SEL;
  a_ready_one_wait: assert property (acc |=> apb_rsp.pready)
    else $error("pready late");
  a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
    else $error("pready outside access");
  a_err_with_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("pslverr without pready");
  a_unmapped_err: assert property (acc && !img && apb_req.paddr > ADDR_TASK_SW
    |=> apb_rsp.pslverr) else $error("unmapped address not refused");
  a_image_no_err: assert property (acc && img |=> !apb_rsp.pslverr)
    else $error("image access refused");
  a_err_read_zero: assert property (rd ##1 apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0)
    else $error("refused read not zero");
  a_byte5_zero: assert property (rd && apb_req.paddr == {IMG_SEL, 10'h004}
    |=> apb_rsp.prdata[15:8] == RESV_BYTE) else $error("image byte 5 not zero");
  a_mask_readback: assert property (rd && apb_req.paddr == {IMG_SEL, 10'h01C}
    |=> apb_rsp.prdata == SUPPORT_MASK) else $error("support mask wrong");
  a_beyond_zero: assert property (rd && img && apb_req.paddr[9:0] >= 10'd416
    |=> apb_rsp.prdata == 32'h0) else $error("beyond image not zero");
  a_irq_after_write: assert property ($changed(irq) |->
    $past(wr_acc, 1) || $past(wr_acc, 2))
    else $error("irq moved without a write");
endmodule : fp_image_asserts

// *** test_fp_state_save_image.sv ***
module test_fp_state_save_image;
  timeunit 1ns;
  timeprecision 1ps;
  import fp_image_pkg::*;
  logic                pclk = 1'b0;  // 250 mhz
  logic                presetn = 1'b0;
  apb_req_t            req = '0;     // master request
  apb_rsp_t            rsp;
  logic                irq;
  logic                lerr;         // last pslverr
  logic         [31:0] q;
  int                  n_errors = 0;
  int                  cmp_count = 0;
  int                  cyc = 0;
  always #2 pclk = ~pclk;
  fp_state_save_image DUT (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .irq(irq));
  // image word address
  function automatic logic [11:0] im(input int w);
    return 12'(12'h400 + 4 * w);
  endfunction : im
  // one apb transfer, held until pready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    lerr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  // single-bit compare
  task automatic c1(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask : c1
  // read and compare word and error
  task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e,
    input logic ee = 1'b0);
    xfer(1'b0, a, 32'h0);
    cmp_count++;
    if (q !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, q);
    end
    c1({n, " err"}, ee, lerr);
  endtask : rc
  task automatic finish_test;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rc("ctrl", ADDR_CTRL, 32'h0);
    rc("int_stat", ADDR_INT_STAT, 32'h0);
    wr(ADDR_CWSW, 32'h0000_037F);
    rc("cwsw", im(0), 32'h0000_037F);
    wr(ADDR_TAG, 32'h0000_83F1);
    rc("tagbyte", im(1), 32'h0000_00E3);
    rc("fulltag", ADDR_TAG, 32'h0000_57F5);
    wr(im(9), 32'h8000_0000);
    wr(im(10), 32'hABCD_3FFF);
    rc("slot0 hi", im(10), 32'h0000_3FFF);
    rc("slot0 pad", im(11), 32'h0);
    rc("fulltag2", ADDR_TAG, 32'h0000_57F4);
    wr(ADDR_CWSW, 32'h0800_037F);
    rc("st7 hi", im(38), 32'h0000_3FFF);
    rc("st0 hi top1", im(10), 32'h0);
    wr(ADDR_CWSW, 32'h0000_037F);
    wr(ADDR_EXEC, 32'h0001_05A5);
    rc("opcode", im(1), 32'h05A5_00E3);
    rc("memref", ADDR_STATUS, 32'h0000_0001);
    wr(ADDR_EXEC, 32'h0002_0123);
    rc("opcode ctl", im(1), 32'h05A5_00E3);
    wr(im(2), 32'h1234_5678);
    wr(im(3), 32'h0000_00CC);
    rc("ip lo", im(2), 32'h1234_5678);
    rc("ip sel", im(3), 32'h0000_00CC);
    wr(im(4), 32'h1111_2222);
    wr(im(5), 32'h0000_0033);
    rc("dp lo", im(4), 32'h1111_2222);
    rc("dp sel", im(5), 32'h0000_0033);
    wr(ADDR_EXEC, 32'h0000_0001);
    rc("dp nomem", im(4), 32'h0);
    wr(ADDR_CTRL, 32'h0000_0003);
    wr(im(3), 32'h9ABC_DEF0);
    rc("ip hi", im(3), 32'h9ABC_DEF0);
    wr(ADDR_MCTL, 32'h0000_1F80);
    rc("mctl", ADDR_MCTL, 32'h0000_1F80);
    rc("img mctl", im(6), 32'h0000_1F80);
    wr(im(40), 32'hDEAD_BEEF);
    rc("xmm0", im(40), 32'hDEAD_BEEF);
    wr(im(72), 32'h5555_AAAA);
    rc("xmm8", im(72), 32'h5555_AAAA);
    wr(ADDR_CTRL, 32'h0000_0001);
    rc("xmm8 legacy", im(72), 32'h0);
    wr(im(72), 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0003);
    rc("xmm8 kept", im(72), 32'h5555_AAAA);
    rc("mask", im(7), SUPPORT_MASK);
    c1("daz", 1'b1, q[6]);
    wr(ADDR_MCTL, 32'hFFFF_1F80 & ((q == 32'h0) ? 32'h0000_FFBF : q));
    rc("mctl masked", ADDR_MCTL, 32'h0000_1F80);
    rc("no fault", ADDR_INT_STAT, 32'h0);
    rc("beyond", im(104), 32'h0);
    wr(ADDR_INT_EN, 32'h0000_0003);
    wr(ADDR_MCTL, 32'h0001_0000);
    rc("mctl kept", ADDR_MCTL, 32'h0000_1F80);
    rc("fault", ADDR_INT_STAT, 32'h0000_0002);
    c1("irq on", 1'b1, irq);
    wr(ADDR_INT_CLR, 32'h0000_0002);
    rc("cleared", ADDR_INT_STAT, 32'h0);
    c1("irq off", 1'b0, irq);
    wr(ADDR_CTRL, 32'h0000_0000);
    rc("img mctl off", im(6), 32'h0);
    rc("xmm0 off", im(40), 32'h0);
    wr(ADDR_TASK_SW, 32'h0);
    rc("lazy set", ADDR_CTRL, 32'h0000_0004);
    wr(ADDR_EXEC, 32'h0001_0777);
    rc("trap", ADDR_INT_STAT, 32'h0000_0001);
    rc("no exec", im(1), 32'h0001_00E3);
    c1("irq trap", 1'b1, irq);
    wr(ADDR_INT_EN, 32'h0);
    rc("masked", ADDR_INT_STAT, 32'h0000_0001);
    c1("irq masked", 1'b0, irq);
    wr(ADDR_INT_CLR, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0002);
    wr(ADDR_EXEC, 32'h0000_0444);
    rc("exec again", im(1), 32'h0444_00E3);
    wr(ADDR_TASK_SW, 32'h0);
    rc("long no set", ADDR_CTRL, 32'h0000_0002);
    rc("unmapped", 12'h028, 32'h0, 1'b1);
    wr(12'h800, 32'h0000_0001);
    c1("wr err", 1'b1, lerr);
    finish_test();
  end
endmodule : test_fp_state_save_image
bind fp_state_save_image fp_image_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .irq(irq));
